// *** design/itcm_top.v ***
// Contract
// - Ten programmable terminals, each with its own command assignment.
// - Code N is active-on; N plus 1000 inverts the terminal first.
// - After reset every terminal uses a plain code N except terminal 5, which gets trip 1009.
// - Codes 69, 98 and 99 refuse their active-off variants.
// - Run forward and reverse codes only go to the two run terminals.
// - Trip 9 and slowdown 66 assert on OFF; trip 1009 asserts on ON.
// - Codes 0, 1 and 2 give speed-step bits of weight 1, 2, 4.
// - Three speed-step bits index one of eight stored speed commands.
// - Coast shuts output at once with no alarm, releases when it drops.
// - Code 24 is the link command enable, code 25 a monitor input.
// - Codes 60, 61 select torque offset bits; code 62 holds it.
// - Code 67 starts load balance compensation; code 69 pole tuning.
// - Codes 101, 102, 103: second trip, torque decrease, contactor ok.
// - Alarm reset clears alarm on assert, hold state on release once held for RST_HOLD_CYC cycles.
// - External trip shuts output, raises alarm, latches until reset.
// - Without any link enable terminal the enable reads as asserted.
`timescale 1ns/1ps
`include "itcm_defines.vh"
module itcm_top #(
    parameter RST_HOLD_CYC = `ITCM_RST_HOLD_CYC
) (
    input  wire        clk_sys,                   // System clock, 50 MHz.
    input  wire        reset_n,                   // Async reset, low.
    input  wire [9:0]  term_pin,                  // Terminals; 8 fwd, 9 rev.
    input  wire [7:0]  reg_addr,                  // Register byte address.
    input  wire [31:0] reg_wdata,                 // Register write data.
    input  wire        reg_wr,                    // Write strobe.
    input  wire        reg_rd,                    // Read strobe.
    output reg  [31:0] reg_rdata,                 // Read data, next cycle.
    output wire        irq,                       // Level interrupt.
    output reg  [2:0]  speed_step_index,          // Selected speed step.
    output reg  [15:0] speed_command,             // Selected speed value.
    output reg         drive_enable,              // Output may run.
    output reg         alarm_output,              // Alarm relay.
    output reg         coast_stop_cmd,            // Coast command.
    output reg         external_trip_cmd,         // Trip input level.
    output reg         external_trip2_cmd,        // Second trip level.
    output reg         inching_enable,            // Jog enable.
    output reg         link_command_enable,       // Link commands allowed.
    output reg         monitor_only_input,        // Monitor-only bit.
    output reg         encoder_vector_enable,     // Encoder vector mode.
    output reg  [1:0]  torque_offset_sel,         // Torque offset select.
    output reg         torque_offset_hold,        // Torque offset hold.
    output reg         backup_supply_run,         // Battery run.
    output reg         no_creep_run_start,        // Creepless start.
    output reg         brake_check_input,         // Brake check.
    output reg         forced_slowdown_cmd,       // Forced slowdown.
    output reg         load_balance_comp_start,   // Balance comp start.
    output reg         pole_offset_tune_cmd,      // Pole offset tuning.
    output reg         run_forward_cmd,           // Run forward.
    output reg         run_backward_cmd,          // Run backward.
    output reg         torque_ref_decrease_start, // Torque decrease start.
    output reg         output_contactor_confirm   // Contactor confirmed.
);

    // Command one-hot for an assignment code.
    function [`ITCM_CMD_W-1:0] code_cmd;
        input [`ITCM_CODE_W-1:0] c;
        reg   [`ITCM_CODE_W-1:0] b;
        begin
            code_cmd = {`ITCM_CMD_W{1'b0}};
            b = (c >= `ITCM_OFF_BASE) ? c - `ITCM_OFF_BASE : c;
            case (b)
                11'h000: code_cmd[`ITCM_C_SS0]   = 1'b1;
                11'h001: code_cmd[`ITCM_C_SS1]   = 1'b1;
                11'h002: code_cmd[`ITCM_C_SS2]   = 1'b1;
                11'h007: code_cmd[`ITCM_C_COAST] = 1'b1;
                11'h008: code_cmd[`ITCM_C_ARST]  = 1'b1;
                11'h009: code_cmd[`ITCM_C_TRIP]  = 1'b1;
                11'h00A: code_cmd[`ITCM_C_JOG]   = 1'b1;
                11'h018: code_cmd[`ITCM_C_LE]    = 1'b1;
                11'h019: code_cmd[`ITCM_C_UDI]   = 1'b1;
                11'h01B: code_cmd[`ITCM_C_PGHZ]  = 1'b1;
                11'h03C: code_cmd[`ITCM_C_TB0]   = 1'b1;
                11'h03D: code_cmd[`ITCM_C_TB1]   = 1'b1;
                11'h03E: code_cmd[`ITCM_C_HTB]   = 1'b1;
                11'h03F: code_cmd[`ITCM_C_BACKUP_SUPPLY_RUN] = 1'b1;
                11'h040: code_cmd[`ITCM_C_NO_CREEP_RUN_START] = 1'b1;
                11'h041: code_cmd[`ITCM_C_BRAKE_CHECK_INPUT]  = 1'b1;
                11'h042: code_cmd[`ITCM_C_DRS]   = 1'b1;
                11'h043: code_cmd[`ITCM_C_LOAD_BALANCE_COMP_START]  = 1'b1;
                11'h045: code_cmd[`ITCM_C_PPT]   = 1'b1;
                11'h062: code_cmd[`ITCM_C_FWD]   = 1'b1;
                11'h063: code_cmd[`ITCM_C_REV]   = 1'b1;
                11'h065: code_cmd[`ITCM_C_TRIP2] = 1'b1;
                11'h066: code_cmd[`ITCM_C_TORQUE_REF_DECREASE_START] = 1'b1;
                11'h067: code_cmd[`ITCM_C_CSMC]  = 1'b1;
                default: code_cmd = {`ITCM_CMD_W{1'b0}};
            endcase
        end
    endfunction

    // Trip and slowdown are fail-safe, so their inversion sense flips.
    function code_inv;
        input [`ITCM_CODE_W-1:0] c;
        begin
            code_inv = (c >= `ITCM_OFF_BASE) ^
                       (c == 11'h009 || c == 11'h042 ||
                        c == 11'h3F1 || c == 11'h42A);
        end
    endfunction

    // A refused code leaves the old assignment in place.
    function code_ok;
        input [31:0] d;
        input [3:0]  t;
        reg   [`ITCM_CODE_W-1:0] c;
        begin
            c = d[`ITCM_CODE_W-1:0];
            code_ok = (d[31:`ITCM_CODE_W] == 21'h000000);
            if (c == `ITCM_CODE_PPT + `ITCM_OFF_BASE ||
                c == `ITCM_CODE_RUN_FWD + `ITCM_OFF_BASE ||
                c == `ITCM_CODE_RUN_REV + `ITCM_OFF_BASE)
                code_ok = 1'b0;
            if ((c == `ITCM_CODE_RUN_FWD || c == `ITCM_CODE_RUN_REV) &&
                t < 4'h8)
                code_ok = 1'b0;
        end
    endfunction

    reg  [`ITCM_CODE_W-1:0]  asg_r [0:`ITCM_NUM_TERM-1];
    reg  [`ITCM_SPEED_W-1:0] speed_r [0:`ITCM_NUM_SPEED-1];
    reg  [9:0]               sync1_r;
    reg  [9:0]               sync2_r;
    reg  [`ITCM_CMD_W-1:0]   cmd_r;
    reg  [`ITCM_CMD_W-1:0]   cmd_nxt;
    reg                      le_assigned;
    reg  [`ITCM_S_W-1:0]     status_r;
    reg  [`ITCM_S_W-1:0]     mask_r;
    reg  [`ITCM_S_W-1:0]     ev;
    reg                      trip_hold_r;
    reg  [18:0]              arst_cnt_r;
    reg                      arst_long_r;
    reg                      bad_wr;
    reg  [31:0]              rd_nxt;
    wire [3:0]               widx;
    wire [2:0]               sidx;
    wire                     trip_any;
    wire                     arst_rise;
    wire                     arst_fall;
    integer                  i;

    assign widx = reg_addr[5:2];
    assign sidx = reg_addr[4:2];
    assign trip_any = cmd_nxt[`ITCM_C_TRIP] | cmd_nxt[`ITCM_C_TRIP2];
    assign arst_rise = cmd_nxt[`ITCM_C_ARST] & ~cmd_r[`ITCM_C_ARST];
    assign arst_fall = ~cmd_nxt[`ITCM_C_ARST] & cmd_r[`ITCM_C_ARST];
    assign irq = |(status_r & mask_r);

    // Two-stage synchroniser on every terminal pin.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 10'h000;
            sync2_r <= 10'h000;
        end else begin
            sync1_r <= term_pin;
            sync2_r <= sync1_r;
        end
    end

    // Commands are the OR of every terminal that carries them.
    always @* begin
        cmd_nxt = {`ITCM_CMD_W{1'b0}};
        le_assigned = 1'b0;
        for (i = 0; i < `ITCM_NUM_TERM; i = i + 1) begin
            if (sync2_r[i] ^ code_inv(asg_r[i]))
                cmd_nxt = cmd_nxt | code_cmd(asg_r[i]);
            if (code_cmd(asg_r[i]) == (24'h000001 << `ITCM_C_LE))
                le_assigned = 1'b1;
        end
        if (!le_assigned)
            cmd_nxt[`ITCM_C_LE] = 1'b1;
    end

    // Events for the sticky status register.
    always @* begin
        bad_wr = reg_wr && reg_addr < 8'h28 &&
                 !code_ok(reg_wdata, widx);
        ev = {`ITCM_S_W{1'b0}};
        ev[`ITCM_S_TRIP]   = cmd_nxt[`ITCM_C_TRIP] &
                             ~cmd_r[`ITCM_C_TRIP];
        ev[`ITCM_S_TRIP2]  = cmd_nxt[`ITCM_C_TRIP2] &
                             ~cmd_r[`ITCM_C_TRIP2];
        ev[`ITCM_S_COAST]  = cmd_nxt[`ITCM_C_COAST] &
                             ~cmd_r[`ITCM_C_COAST];
        ev[`ITCM_S_BADSET] = bad_wr;
        ev[`ITCM_S_ARST]   = arst_rise;
    end

    // Register writes.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            asg_r[0] <= `ITCM_RST_ASSIGN0;
            asg_r[1] <= `ITCM_RST_ASSIGN1;
            asg_r[2] <= `ITCM_RST_ASSIGN2;
            asg_r[3] <= `ITCM_RST_ASSIGN3;
            asg_r[4] <= `ITCM_RST_ASSIGN4;
            asg_r[5] <= `ITCM_RST_ASSIGN5;
            asg_r[6] <= `ITCM_RST_ASSIGN6;
            asg_r[7] <= `ITCM_RST_ASSIGN7;
            asg_r[8] <= `ITCM_CODE_RUN_FWD;
            asg_r[9] <= `ITCM_CODE_RUN_REV;
            for (i = 0; i < `ITCM_NUM_SPEED; i = i + 1)
                speed_r[i] <= 16'h0000;
            mask_r   <= 5'h00;
            status_r <= 5'h00;
        end else begin
            if (reg_wr && reg_addr < 8'h28 && !bad_wr)
                asg_r[widx] <= reg_wdata[`ITCM_CODE_W-1:0];
            if (reg_wr && reg_addr >= `ITCM_OFS_SPEED0 &&
                reg_addr < 8'h60)
                speed_r[sidx] <= reg_wdata[`ITCM_SPEED_W-1:0];
            if (reg_wr && reg_addr == `ITCM_OFS_MASK)
                mask_r <= reg_wdata[`ITCM_S_W-1:0];
            // A new event wins over a clear in the same cycle.
            if (reg_wr && reg_addr == `ITCM_OFS_STATUS)
                status_r <= (status_r & ~reg_wdata[`ITCM_S_W-1:0]) | ev;
            else
                status_r <= status_r | ev;
        end
    end

    // Alarm, trip hold and alarm reset timing.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trip_hold_r  <= 1'b0;
            alarm_output <= 1'b0;
            arst_cnt_r   <= 19'h00000;
            arst_long_r  <= 1'b0;
            drive_enable <= 1'b0;
        end else begin
            if (cmd_r[`ITCM_C_ARST]) begin
                if (arst_cnt_r >= RST_HOLD_CYC[18:0] - 19'h00001)
                    arst_long_r <= 1'b1;
                else
                    arst_cnt_r <= arst_cnt_r + 19'h00001;
            end else begin
                arst_cnt_r  <= 19'h00000;
                arst_long_r <= 1'b0;
            end
            if (trip_any) begin
                trip_hold_r  <= 1'b1;
                alarm_output <= 1'b1;
            end else begin
                if (arst_rise)
                    alarm_output <= 1'b0;
                if (arst_fall && arst_long_r)
                    trip_hold_r <= 1'b0;
            end
            drive_enable <= ~cmd_nxt[`ITCM_C_COAST] &
                            ~trip_any & ~trip_hold_r;
        end
    end

    // Registered command outputs.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cmd_r                     <= 24'h000000;
            speed_step_index          <= 3'h0;
            speed_command             <= 16'h0000;
            coast_stop_cmd            <= 1'b0;
            external_trip_cmd         <= 1'b0;
            external_trip2_cmd        <= 1'b0;
            inching_enable            <= 1'b0;
            link_command_enable       <= 1'b0;
            monitor_only_input        <= 1'b0;
            encoder_vector_enable     <= 1'b0;
            torque_offset_sel         <= 2'h0;
            torque_offset_hold        <= 1'b0;
            backup_supply_run         <= 1'b0;
            no_creep_run_start        <= 1'b0;
            brake_check_input         <= 1'b0;
            forced_slowdown_cmd       <= 1'b0;
            load_balance_comp_start   <= 1'b0;
            pole_offset_tune_cmd      <= 1'b0;
            run_forward_cmd           <= 1'b0;
            run_backward_cmd          <= 1'b0;
            torque_ref_decrease_start <= 1'b0;
            output_contactor_confirm  <= 1'b0;
        end else begin
            cmd_r            <= cmd_nxt;
            speed_step_index <= cmd_nxt[2:0];
            speed_command    <= speed_r[cmd_nxt[2:0]];
            coast_stop_cmd            <= cmd_nxt[`ITCM_C_COAST];
            external_trip_cmd         <= cmd_nxt[`ITCM_C_TRIP];
            external_trip2_cmd        <= cmd_nxt[`ITCM_C_TRIP2];
            inching_enable            <= cmd_nxt[`ITCM_C_JOG];
            link_command_enable       <= cmd_nxt[`ITCM_C_LE];
            monitor_only_input        <= cmd_nxt[`ITCM_C_UDI];
            encoder_vector_enable     <= cmd_nxt[`ITCM_C_PGHZ];
            torque_offset_sel         <= cmd_nxt[11:10];
            torque_offset_hold        <= cmd_nxt[`ITCM_C_HTB];
            backup_supply_run         <= cmd_nxt[`ITCM_C_BACKUP_SUPPLY_RUN];
            no_creep_run_start        <= cmd_nxt[`ITCM_C_NO_CREEP_RUN_START];
            brake_check_input         <= cmd_nxt[`ITCM_C_BRAKE_CHECK_INPUT];
            forced_slowdown_cmd       <= cmd_nxt[`ITCM_C_DRS];
            load_balance_comp_start   <= cmd_nxt[`ITCM_C_LOAD_BALANCE_COMP_START];
            pole_offset_tune_cmd      <= cmd_nxt[`ITCM_C_PPT];
            run_forward_cmd           <= cmd_nxt[`ITCM_C_FWD];
            run_backward_cmd          <= cmd_nxt[`ITCM_C_REV];
            torque_ref_decrease_start <= cmd_nxt[`ITCM_C_TORQUE_REF_DECREASE_START];
            output_contactor_confirm  <= cmd_nxt[`ITCM_C_CSMC];
        end
    end

    // Read mux; unmapped addresses read zero.
    always @* begin
        rd_nxt = 32'h00000000;
        if (reg_addr < 8'h28)
            rd_nxt[`ITCM_CODE_W-1:0] = asg_r[widx];
        else if (reg_addr == `ITCM_OFS_STATUS)
            rd_nxt[`ITCM_S_W-1:0] = status_r;
        else if (reg_addr == `ITCM_OFS_MASK)
            rd_nxt[`ITCM_S_W-1:0] = mask_r;
        else if (reg_addr == `ITCM_OFS_CMD)
            rd_nxt[`ITCM_CMD_W-1:0] = cmd_r;
        else if (reg_addr == `ITCM_OFS_STATE)
            rd_nxt[3:0] = {trip_hold_r, alarm_output, drive_enable,
                           arst_long_r};
        else if (reg_addr >= `ITCM_OFS_SPEED0 && reg_addr < 8'h60)
            rd_nxt[`ITCM_SPEED_W-1:0] = speed_r[sidx];
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
            reg_rdata <= rd_nxt;
        else
            reg_rdata <= 32'h00000000;
    end

endmodule // itcm_top

// *** inc/itcm_defines.vh ***
`ifndef ITCM_DEFINES_VH
`define ITCM_DEFINES_VH

// Register byte offsets.
`define ITCM_OFS_ASSIGN0   8'h00
`define ITCM_OFS_STATUS    8'h28
`define ITCM_OFS_MASK      8'h2C
`define ITCM_OFS_CMD       8'h30
`define ITCM_OFS_STATE     8'h34
`define ITCM_OFS_SPEED0    8'h40
`define ITCM_NUM_TERM      10
`define ITCM_NUM_SPEED     8
`define ITCM_CODE_W        11
`define ITCM_SPEED_W       16
`define ITCM_CMD_W         24

// Assignment codes.
`define ITCM_OFF_BASE      11'h3E8
`define ITCM_CODE_RUN_FWD  11'h062
`define ITCM_CODE_RUN_REV  11'h063
`define ITCM_CODE_PPT      11'h045

// Reset values of the assignments.
`define ITCM_RST_ASSIGN0   11'h000
`define ITCM_RST_ASSIGN1   11'h001
`define ITCM_RST_ASSIGN2   11'h002
`define ITCM_RST_ASSIGN3   11'h007
`define ITCM_RST_ASSIGN4   11'h008
`define ITCM_RST_ASSIGN5   11'h3F1
`define ITCM_RST_ASSIGN6   11'h00A
`define ITCM_RST_ASSIGN7   11'h019

// Command vector bit positions.
`define ITCM_C_SS0     0
`define ITCM_C_SS1     1
`define ITCM_C_SS2     2
`define ITCM_C_COAST   3
`define ITCM_C_ARST    4
`define ITCM_C_TRIP    5
`define ITCM_C_JOG     6
`define ITCM_C_LE      7
`define ITCM_C_UDI     8
`define ITCM_C_PGHZ    9
`define ITCM_C_TB0     10
`define ITCM_C_TB1     11
`define ITCM_C_HTB     12
`define ITCM_C_BACKUP_SUPPLY_RUN   13
`define ITCM_C_NO_CREEP_RUN_START   14
`define ITCM_C_BRAKE_CHECK_INPUT    15
`define ITCM_C_DRS     16
`define ITCM_C_LOAD_BALANCE_COMP_START    17
`define ITCM_C_PPT     18
`define ITCM_C_FWD     19
`define ITCM_C_REV     20
`define ITCM_C_TRIP2   21
`define ITCM_C_TORQUE_REF_DECREASE_START   22
`define ITCM_C_CSMC    23

// Status and mask bit positions.
`define ITCM_S_TRIP    0
`define ITCM_S_TRIP2   1
`define ITCM_S_COAST   2
`define ITCM_S_BADSET  3
`define ITCM_S_ARST    4
`define ITCM_S_W       5

// Alarm reset least hold time.
`define ITCM_CLK_KHZ       50000
`define ITCM_RST_HOLD_MS   10
`define ITCM_RST_HOLD_CYC  (`ITCM_RST_HOLD_MS * `ITCM_CLK_KHZ)

`endif

// *** testbench/itcm_props.sv ***
`timescale 1ns/1ps
module itcm_props #(
    parameter RST_HOLD_CYC = 8
) (
    input wire        clk_sys,            // System clock.
    input wire        reset_n,            // Async reset, low.
    input wire [7:0]  reg_addr,           // Register address.
    input wire        reg_rd,             // Read strobe.
    input wire [31:0] reg_rdata,          // Read data.
    input wire [2:0]  speed_step_index,   // Speed step index.
    input wire        drive_enable,       // Output may run.
    input wire        alarm_output,       // Alarm relay.
    input wire        coast_stop_cmd,     // Coast command.
    input wire        external_trip_cmd,  // Trip level.
    input wire        external_trip2_cmd  // Second trip level.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_trip_rise;
        $rose(external_trip_cmd) || $rose(external_trip2_cmd);
    endsequence

    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0) else $error("read data not idle");
    chk_unmapped_zero: assert property (
        s_rd(8'hFC) |=> reg_rdata == 32'h0) else $error("unmapped read");
    chk_assign_width: assert property (
        reg_rd && reg_addr < 8'h28 |=> reg_rdata[31:11] == 21'h0)
        else $error("assignment read too wide");
    chk_cmd_speed: assert property (
        s_rd(8'h30) |=> reg_rdata[2:0] == $past(speed_step_index) &&
        reg_rdata[31:24] == 8'h00) else $error("speed bits readback");
    chk_cmd_levels: assert property (
        s_rd(8'h30) |=> reg_rdata[3] == $past(coast_stop_cmd) &&
        reg_rdata[5] == $past(external_trip_cmd))
        else $error("command readback");
    chk_coast_stops: assert property (
        $rose(coast_stop_cmd) |-> ##[0:1] !drive_enable)
        else $error("coast did not stop output");
    chk_coast_quiet: assert property (
        coast_stop_cmd && !alarm_output && !external_trip_cmd &&
        !external_trip2_cmd |=> !alarm_output || external_trip_cmd ||
        external_trip2_cmd) else $error("coast raised an alarm");
    chk_trip_alarm: assert property (
        s_trip_rise |-> ##[0:2] (alarm_output && !drive_enable))
        else $error("trip did not raise alarm");
    chk_alarm_latch: assert property (
        $fell(alarm_output) |-> !external_trip_cmd && !external_trip2_cmd)
        else $error("alarm cleared during trip");
    chk_alarm_stop: assert property (
        alarm_output [*2] |-> !drive_enable)
        else $error("output runs during alarm");
endmodule // itcm_props

bind itcm_top itcm_props #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_itcm_props (
    .clk_sys, .reset_n, .reg_addr, .reg_rd, .reg_rdata, .speed_step_index,
    .drive_enable, .alarm_output, .coast_stop_cmd, .external_trip_cmd,
    .external_trip2_cmd);

// *** testbench/itcm_switch_bank.sv ***
`timescale 1ns/1ps
module itcm_switch_bank #(
    parameter HOLD_CYC = 10
) (
    input  wire       clk_sys,   // Bench clock.
    input  wire [9:0] lvl,       // Requested switch levels.
    input  wire [9:0] hold_mask, // Switches with a least on time.
    output reg  [9:0] term_pin   // Levels at the terminals.
);
    int cnt [10];
    initial term_pin = 10'h000;
    // A masked switch, once on, stays on for HOLD_CYC cycles.
    always @(posedge clk_sys) begin
        for (int i = 0; i < 10; i++) begin
            if (lvl[i] || (hold_mask[i] && term_pin[i] &&
                cnt[i] < HOLD_CYC)) begin
                term_pin[i] <= 1'b1;
                cnt[i] <= cnt[i] + 1;
            end else begin
                term_pin[i] <= 1'b0;
                cnt[i] <= 0;
            end
        end
    end
endmodule // itcm_switch_bank

// *** testbench/itcm_tb_top.sv ***
`timescale 1ns/1ps
module itcm_tb_top;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [9:0]  lvl = 10'h000;
    logic [9:0]  hold_mask = 10'h010;
    wire  [9:0]  term_pin;
    wire  [31:0] reg_rdata;
    wire  [2:0]  speed_step_index;
    wire  [15:0] speed_command;
    wire  [1:0]  torque_offset_sel;
    wire         irq, drive_enable, alarm_output, coast_stop_cmd;
    wire         external_trip_cmd, external_trip2_cmd, inching_enable;
    wire         link_command_enable, monitor_only_input, run_forward_cmd;
    wire         encoder_vector_enable, torque_offset_hold, backup_supply_run;
    wire         no_creep_run_start, brake_check_input, forced_slowdown_cmd;
    wire         load_balance_comp_start, pole_offset_tune_cmd;
    wire         run_backward_cmd, torque_ref_decrease_start;
    wire         output_contactor_confirm;
    wire  [23:0] outs;
    integer      err_count = 0;
    integer      check_count = 0;
    integer      seed = 19842;
    int          asg [10] = '{0, 1, 2, 7, 8, 1009, 10, 25, 98, 99};
    int          code_tab [24] = '{0, 1, 2, 7, 8, 9, 10, 24, 25, 27, 60, 61,
                                   62, 63, 64, 65, 66, 67, 69, 98, 99, 101,
                                   102, 103};
    int          bad_t [6] = '{0, 8, 9, 3, 4, 2};
    int          bad_c [6] = '{1069, 1098, 1099, 98, 99, 2048};
    logic [15:0] spd [8];
    logic [31:0] d;

    always #10 clk_sys = ~clk_sys;

    assign outs = {output_contactor_confirm, torque_ref_decrease_start,
        external_trip2_cmd, run_backward_cmd, run_forward_cmd,
        pole_offset_tune_cmd, load_balance_comp_start, forced_slowdown_cmd,
        brake_check_input, no_creep_run_start, backup_supply_run,
        torque_offset_hold, torque_offset_sel, encoder_vector_enable,
        monitor_only_input, link_command_enable, inching_enable,
        external_trip_cmd, 1'b0, coast_stop_cmd, speed_step_index};

    itcm_switch_bank #(.HOLD_CYC(10)) i_itcm_switch_bank (
        .clk_sys, .lvl, .hold_mask, .term_pin);

    itcm_top #(.RST_HOLD_CYC(8)) i_itcm_top (
        .clk_sys, .reset_n, .term_pin, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq, .speed_step_index, .speed_command,
        .drive_enable, .alarm_output, .coast_stop_cmd, .external_trip_cmd,
        .external_trip2_cmd, .inching_enable, .link_command_enable,
        .monitor_only_input, .encoder_vector_enable, .torque_offset_sel,
        .torque_offset_hold, .backup_supply_run, .no_creep_run_start,
        .brake_check_input, .forced_slowdown_cmd, .load_balance_comp_start,
        .pole_offset_tune_cmd, .run_forward_cmd, .run_backward_cmd,
        .torque_ref_decrease_start, .output_contactor_confirm);

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic set_asg(input int t, input int c);
        wr(8'(4 * t), 32'(c));
        asg[t] = c;
    endtask

    task automatic pins(input logic [9:0] v);
        @(posedge clk_sys);
        lvl <= v;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask

    function automatic logic [23:0] model_cmd(input logic [9:0] p);
        logic [23:0] v;
        bit          inv, le;
        int          b;
        v = 24'h0;
        le = 1'b0;
        for (int t = 0; t < 10; t++) begin
            b = asg[t] % 1000;
            inv = asg[t] >= 1000;
            if (b == 9 || b == 66) inv = !inv;
            for (int k = 0; k < 24; k++) begin
                if (code_tab[k] == b) begin
                    v[k] = v[k] | (p[t] ^ inv);
                    if (k == 7) le = 1'b1;
                end
            end
        end
        if (!le) v[7] = 1'b1;
        return v;
    endfunction

    task automatic check_cmd;
        logic [23:0] e;
        logic [31:0] r;
        e = model_cmd(lvl);
        rd(8'h30, r);
        chk("cmd_readback", {8'h0, e}, r);
        chk("cmd_ports", {8'h0, e & 24'hFFFFEF}, {8'h0, outs & 24'hFFFFEF});
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count = err_count + 1;
        end_of_test;
    end

    initial begin : main
        int t, k, c;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (t = 0; t < 10; t++) begin
            rd(8'(4 * t), d);
            chk("assign_reset", 32'(asg[t]), d);
        end
        check_cmd;
        rd(8'hFC, d);
        chk("unmapped", 32'h0, d);
        for (k = 0; k < 8; k++) begin
            spd[k] = 16'($random(seed));
            wr(8'h40 + 8'(4 * k), {16'h0, spd[k]});
        end
        for (k = 0; k < 8; k++) begin
            pins(10'(k));
            chk("speed_index", 32'(k), {29'h0, speed_step_index});
            chk("speed_cmd", {16'h0, spd[k]}, {16'h0, speed_command});
        end
        for (k = 0; k < 6; k++) begin
            wr(8'(4 * bad_t[k]), 32'(bad_c[k]));
            rd(8'(4 * bad_t[k]), d);
            chk("refused", 32'(asg[bad_t[k]]), d);
        end
        rd(8'h28, d);
        chk("status", 32'h8, d);
        chk1("irq_masked", 1'b0, irq);
        wr(8'h2C, 32'h8);
        #1 chk1("irq_set", 1'b1, irq);
        wr(8'h28, 32'h8);
        #1 chk1("irq_clear", 1'b0, irq);
        pins(10'h008);
        chk1("coast", 1'b1, coast_stop_cmd);
        chk1("coast_drive", 1'b0, drive_enable);
        chk1("coast_alarm", 1'b0, alarm_output);
        pins(10'h000);
        chk1("coast_release", 1'b1, drive_enable);
        pins(10'h020);
        chk1("trip_alarm", 1'b1, alarm_output);
        pins(10'h000);
        chk1("trip_latch", 1'b1, alarm_output);
        pins(10'h010);
        pins(10'h000);
        pins(10'h000);
        chk1("reset_alarm", 1'b0, alarm_output);
        chk1("reset_drive", 1'b1, drive_enable);
        pins(10'h020);
        pins(10'h000);
        hold_mask <= 10'h000;
        @(posedge clk_sys);
        lvl <= 10'h010;
        pins(10'h000);
        chk1("short_alarm", 1'b0, alarm_output);
        chk1("short_hold", 1'b0, drive_enable);
        set_asg(6, 101);
        set_asg(7, 24);
        pins(10'h040);
        chk1("trip2_alarm", 1'b1, alarm_output);
        check_cmd;
        for (k = 0; k < 40; k++) begin
            t = {$random(seed)} % 10;
            c = code_tab[{$random(seed)} % 24];
            if (t < 8 && (c == 98 || c == 99)) c = 500;
            else if (c != 69 && c != 98 && c != 99 && $random(seed) % 2)
                c = c + 1000;
            set_asg(t, c);
            pins(10'($random(seed)));
            check_cmd;
        end
        end_of_test;
    end
endmodule // itcm_tb_top
